// File: design/nvm_irq_defs.svh
// Purpose: offsets, field positions and reset values of the event
//          interrupt register set
// Assumes: 32-bit aligned words on the register bus
// Notes:   definitions only
`ifndef NVM_IRQ_DEFS_SVH
`define NVM_IRQ_DEFS_SVH

`define NUM_SRC 10
`define ADDR_W 12

`define OFS_ENABLE_CLEAR_CMD 12'hfd8
`define OFS_ENABLE_SET_CMD 12'hfdc
`define OFS_PENDING_FLAGS 12'hfe0
`define OFS_ENABLE_MASK 12'hfe4
`define OFS_PENDING_CLEAR_CMD 12'hfe8
`define OFS_PENDING_SET_CMD 12'hfec

`define SRC_EEPROM_DONE 0
`define SRC_BANK0_DONE 1
`define SRC_BANK1_DONE 2
`define SRC_EEPROM_HV_FAULT 3
`define SRC_BANK0_HV_FAULT 4
`define SRC_BANK1_HV_FAULT 5
`define SRC_BANK0_ECC_INVALID 6
`define SRC_BANK0_ECC_UNCORR 7
`define SRC_BANK1_ECC_INVALID 8
`define SRC_BANK1_ECC_UNCORR 9

`define FLAGS_RESET 10'h000
`define WORD_ZERO 32'h0000_0000

`endif

// File: design/nvm_irq_pkg.sv
// Purpose: shared types of the event interrupt register set
// Assumes: nvm_irq_defs.svh gives the widths
// Notes:   types only, numbers live in the header
`include "nvm_irq_defs.svh"

package nvm_irq_pkg;

    typedef logic [`NUM_SRC-1:0] src_vec_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_ENABLE_CLEAR,
        SEL_ENABLE_SET,
        SEL_PENDING,
        SEL_ENABLE,
        SEL_PENDING_CLEAR,
        SEL_PENDING_SET
    } reg_sel_e;

    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_RESP
    } bus_state_e;

endpackage

// File: design/flag_cmd_if.sv
// Purpose: set/clear command path between the register front end
//          and one bank of sticky flags
// Assumes: one clock domain
// Notes:   the bank owns the flags, the front end owns the commands
`timescale 1ns/10ps

interface flag_cmd_if #(
    parameter int W = 10
);
    logic [W-1:0] set_vec;
    logic [W-1:0] clr_vec;
    logic [W-1:0] flags;

    modport bank (
        input set_vec,
        input clr_vec,
        output flags
    );

    modport user (
        output set_vec,
        output clr_vec,
        input flags
    );
endinterface

// File: design/flag_bank.sv
// Purpose: bank of sticky flags with per-bit set and clear
// Assumes: set and clear vectors are single-cycle commands
// Notes:   a set in the same cycle as a clear wins
`timescale 1ns/10ps

module flag_bank
    import nvm_irq_pkg::*;
#(
    parameter int W = 10,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command path
    flag_cmd_if.bank cmd
);
    typedef struct packed {
        logic [W-1:0] flags;
    } bank_s;

    bank_s s;
    bank_s next_s;

    always_comb begin
        next_s = s;
        // set after clear so an event never drops under a clear
        next_s.flags = (s.flags & ~cmd.clr_vec) | cmd.set_vec;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s.flags <= RESET_VAL;
        end else begin
            s <= next_s;
        end
    end

    assign cmd.flags = s.flags;
endmodule

// File: design/reg_decode.sv
// Purpose: maps a bus word address onto one of the six registers
// Assumes: byte address, low two bits ignored
// Notes:   purely combinational
`timescale 1ns/10ps
`include "nvm_irq_defs.svh"

module reg_decode
    import nvm_irq_pkg::*;
#(
    parameter int AW = `ADDR_W
) (
    // address in
    input wire logic [AW-1:0] addr,
    // selection out
    output reg_sel_e sel
);
    always_comb begin
        // low bits forced to zero so the compare is offset against offset
        case ({addr[AW-1:2], 2'b00})
            `OFS_ENABLE_CLEAR_CMD: sel = SEL_ENABLE_CLEAR;
            `OFS_ENABLE_SET_CMD: sel = SEL_ENABLE_SET;
            `OFS_PENDING_FLAGS: sel = SEL_PENDING;
            `OFS_ENABLE_MASK: sel = SEL_ENABLE;
            `OFS_PENDING_CLEAR_CMD: sel = SEL_PENDING_CLEAR;
            `OFS_PENDING_SET_CMD: sel = SEL_PENDING_SET;
            default: sel = SEL_NONE;
        endcase
    end
endmodule

// File: design/nvm_event_interrupt_regs.sv
// Purpose: interrupt status and enable registers for the events of a
//          nonvolatile memory controller, reached over APB
// Assumes: event inputs synchronous to REF_CLK, high for each cycle
//          in which the event is signalled
// Notes:   APB answers one cycle into the access phase
//
// Function
// - one bit per source: 0-2 done, 3-5 high voltage, 6-9 ECC reads
// - enable-set command sets each enable bit written one
// - enable-clear command clears each enable bit written one
// - enable register reads current enables, writes to it ignored
// - status register reads pending flags, set by controller events
// - status-clear command clears each pending bit written one
// - status-set command sets pending bits, software raises events
// - bits 31:10 read zero, writes ignored; flags reset to zero
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`include "nvm_irq_defs.svh"

module nvm_event_interrupt_regs
    import nvm_irq_pkg::*;
#(
    parameter int AW = `ADDR_W
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // memory controller events
    input wire logic EEPROM_WRITE_DONE,
    input wire logic BANK0_WRITE_DONE,
    input wire logic BANK1_WRITE_DONE,
    input wire logic EEPROM_HV_FAULT,
    input wire logic BANK0_HV_FAULT,
    input wire logic BANK1_HV_FAULT,
    input wire logic BANK0_ECC_INVALID,
    input wire logic BANK0_ECC_UNCORR,
    input wire logic BANK1_ECC_INVALID,
    input wire logic BANK1_ECC_UNCORR,
    // interrupt request
    output logic IRQ
);

    typedef struct packed {
        bus_state_e bus_st;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic irq;
    } top_s;

    top_s s;
    top_s next_s;

    reg_sel_e sel;
    src_vec_t events;
    src_vec_t wr_bits;
    logic wr_commit;
    logic rd_capture;
    logic wr_enable_set;
    logic wr_enable_clear;
    logic wr_pending_set;
    logic wr_pending_clear;
    src_vec_t pend_now;
    src_vec_t ena_now;
    src_vec_t pend_set;
    src_vec_t pend_clr;
    src_vec_t ena_set;
    src_vec_t ena_clr;
    src_vec_t status_view;

    // per-source view of the pending flags
    logic eeprom_write_done_flag;
    logic bank0_write_done_flag;
    logic bank1_write_done_flag;
    logic eeprom_high_voltage_fault_flag;
    logic bank0_high_voltage_fault_flag;
    logic bank1_high_voltage_fault_flag;
    logic bank0_ecc_invalid_flag;
    logic bank0_ecc_uncorr_flag;
    logic bank1_ecc_invalid_flag;
    logic bank1_ecc_uncorr_flag;

    flag_cmd_if #(.W(`NUM_SRC)) pending_if ();
    flag_cmd_if #(.W(`NUM_SRC)) enable_if ();

    // byte lanes of the write data that the strobes let through
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = `WORD_ZERO;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // flags widened onto a bus word, upper bits held at zero
    function automatic logic [31:0] to_word(input src_vec_t v);
        logic [31:0] w;
        w = `WORD_ZERO;
        w[`NUM_SRC-1:0] = v;
        return w;
    endfunction

    // read value of a selected register; command words read zero
    function automatic logic [31:0] read_word(
        input reg_sel_e rsel,
        input src_vec_t pend,
        input src_vec_t ena
    );
        logic [31:0] w;
        w = `WORD_ZERO;
        case (rsel)
            SEL_PENDING: w = to_word(pend);
            SEL_ENABLE: w = to_word(ena);
            default: w = `WORD_ZERO;
        endcase
        return w;
    endfunction

    // true for the four write-only command words
    function automatic logic is_command(input reg_sel_e rsel);
        logic c;
        c = 1'b0;
        case (rsel)
            SEL_ENABLE_CLEAR: c = 1'b1;
            SEL_ENABLE_SET: c = 1'b1;
            SEL_PENDING_CLEAR: c = 1'b1;
            SEL_PENDING_SET: c = 1'b1;
            default: c = 1'b0;
        endcase
        return c;
    endfunction

    // only the six words answer without an error
    function automatic logic is_mapped(input reg_sel_e rsel);
        return (rsel != SEL_NONE);
    endfunction

    // ones of a command word, on enabled lanes, as per-source actions
    function automatic src_vec_t cmd_bits(
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        logic [31:0] masked;
        masked = wdata & lane_mask(strb);
        return masked[`NUM_SRC-1:0];
    endfunction

    // one event line per source, each in its own bit position
    function automatic src_vec_t pack_events(
        input logic eeprom_done,
        input logic bank0_done,
        input logic bank1_done,
        input logic eeprom_hv,
        input logic bank0_hv,
        input logic bank1_hv,
        input logic bank0_ecc_inv,
        input logic bank0_ecc_unc,
        input logic bank1_ecc_inv,
        input logic bank1_ecc_unc
    );
        src_vec_t v;
        v = '0;
        v[`SRC_EEPROM_DONE] = eeprom_done;
        v[`SRC_BANK0_DONE] = bank0_done;
        v[`SRC_BANK1_DONE] = bank1_done;
        v[`SRC_EEPROM_HV_FAULT] = eeprom_hv;
        v[`SRC_BANK0_HV_FAULT] = bank0_hv;
        v[`SRC_BANK1_HV_FAULT] = bank1_hv;
        v[`SRC_BANK0_ECC_INVALID] = bank0_ecc_inv;
        v[`SRC_BANK0_ECC_UNCORR] = bank0_ecc_unc;
        v[`SRC_BANK1_ECC_INVALID] = bank1_ecc_inv;
        v[`SRC_BANK1_ECC_UNCORR] = bank1_ecc_unc;
        return v;
    endfunction

    reg_decode #(
        .AW(AW)
    ) u_decode (
        .addr(PADDR),
        .sel(sel)
    );

    flag_bank #(
        .W(`NUM_SRC),
        .RESET_VAL(`FLAGS_RESET)
    ) u_pending (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .cmd(pending_if)
    );

    flag_bank #(
        .W(`NUM_SRC),
        .RESET_VAL(`FLAGS_RESET)
    ) u_enable (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .cmd(enable_if)
    );

    // gather the event lines into their bit positions
    assign events = pack_events(
        EEPROM_WRITE_DONE,
        BANK0_WRITE_DONE,
        BANK1_WRITE_DONE,
        EEPROM_HV_FAULT,
        BANK0_HV_FAULT,
        BANK1_HV_FAULT,
        BANK0_ECC_INVALID,
        BANK0_ECC_UNCORR,
        BANK1_ECC_INVALID,
        BANK1_ECC_UNCORR
    );

    // a write lands only at the edge where the master sees PREADY
    always_comb begin
        wr_commit = (s.bus_st == BUS_RESP) && s.ready && PSEL &&
            PENABLE && PWRITE;
        // upper bits dropped so they can never act
        wr_bits = cmd_bits(PWDATA, PSTRB);
        wr_enable_set = wr_commit && (sel == SEL_ENABLE_SET);
        wr_enable_clear = wr_commit && (sel == SEL_ENABLE_CLEAR);
        wr_pending_set = wr_commit && (sel == SEL_PENDING_SET);
        wr_pending_clear = wr_commit && (sel == SEL_PENDING_CLEAR);
    end

    // the read snapshot is taken in the first access cycle
    always_comb begin
        rd_capture = (s.bus_st == BUS_IDLE) && PSEL && PENABLE;
    end

    // pending bank: events always set, software sets and clears
    always_comb begin
        pend_set = events;
        pend_clr = '0;
        if (wr_pending_set) begin
            pend_set = events | wr_bits;
        end
        if (wr_pending_clear) begin
            // a coincident event still sets, the bank favours set
            pend_clr = wr_bits;
        end
    end

    // enable bank: only the two enable commands reach it, so writes to
    // the read-only words and to holes change nothing
    always_comb begin
        ena_set = '0;
        ena_clr = '0;
        if (wr_enable_set) begin
            ena_set = wr_bits;
        end
        if (wr_enable_clear) begin
            ena_clr = wr_bits;
        end
    end

    // onto the command paths of the two banks
    assign pending_if.set_vec = pend_set;
    assign pending_if.clr_vec = pend_clr;
    assign enable_if.set_vec = ena_set;
    assign enable_if.clr_vec = ena_clr;
    assign pend_now = pending_if.flags;
    assign ena_now = enable_if.flags;

    // per-source names of the pending flags
    assign eeprom_write_done_flag = pend_now[`SRC_EEPROM_DONE];
    assign bank0_write_done_flag = pend_now[`SRC_BANK0_DONE];
    assign bank1_write_done_flag = pend_now[`SRC_BANK1_DONE];
    assign eeprom_high_voltage_fault_flag = pend_now[`SRC_EEPROM_HV_FAULT];
    assign bank0_high_voltage_fault_flag = pend_now[`SRC_BANK0_HV_FAULT];
    assign bank1_high_voltage_fault_flag = pend_now[`SRC_BANK1_HV_FAULT];
    assign bank0_ecc_invalid_flag = pend_now[`SRC_BANK0_ECC_INVALID];
    assign bank0_ecc_uncorr_flag = pend_now[`SRC_BANK0_ECC_UNCORR];
    assign bank1_ecc_invalid_flag = pend_now[`SRC_BANK1_ECC_INVALID];
    assign bank1_ecc_uncorr_flag = pend_now[`SRC_BANK1_ECC_UNCORR];

    // status word assembled field by field from the named flags
    always_comb begin
        status_view = '0;
        status_view[`SRC_EEPROM_DONE] = eeprom_write_done_flag;
        status_view[`SRC_BANK0_DONE] = bank0_write_done_flag;
        status_view[`SRC_BANK1_DONE] = bank1_write_done_flag;
        status_view[`SRC_EEPROM_HV_FAULT] =
            eeprom_high_voltage_fault_flag;
        status_view[`SRC_BANK0_HV_FAULT] = bank0_high_voltage_fault_flag;
        status_view[`SRC_BANK1_HV_FAULT] = bank1_high_voltage_fault_flag;
        status_view[`SRC_BANK0_ECC_INVALID] = bank0_ecc_invalid_flag;
        status_view[`SRC_BANK0_ECC_UNCORR] = bank0_ecc_uncorr_flag;
        status_view[`SRC_BANK1_ECC_INVALID] = bank1_ecc_invalid_flag;
        status_view[`SRC_BANK1_ECC_UNCORR] = bank1_ecc_uncorr_flag;
    end

    // bus answer state and the registered interrupt line
    always_comb begin
        next_s = s;
        next_s.ready = 1'b0;
        next_s.slverr = 1'b0;
        case (s.bus_st)
            BUS_IDLE: begin
                if (rd_capture) begin
                    next_s.bus_st = BUS_RESP;
                    next_s.ready = 1'b1;
                    next_s.slverr = !is_mapped(sel);
                    if (PWRITE || is_command(sel)) begin
                        next_s.rdata = `WORD_ZERO;
                    end else begin
                        next_s.rdata = read_word(sel, status_view, ena_now);
                    end
                end
            end
            BUS_RESP: begin
                // one idle cycle lets penable fall before a new access
                next_s.bus_st = BUS_IDLE;
            end
            default: begin
                next_s.bus_st = BUS_IDLE;
            end
        endcase
        next_s.irq = |(pend_now & ena_now);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s.bus_st <= BUS_IDLE;
            s.ready <= 1'b0;
            s.slverr <= 1'b0;
            s.rdata <= `WORD_ZERO;
            s.irq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign PRDATA = s.rdata;
    assign PREADY = s.ready;
    assign PSLVERR = s.slverr;
    assign IRQ = s.irq;

endmodule

// File: dv/nvm_irq_chk_properties.sv
// Purpose: bus and interrupt properties of the event register set
// Assumes: bound to the top module
// Notes: answer one cycle into the access phase
`timescale 1ns/10ps

module nvm_irq_chk #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // interrupt
    input wire logic IRQ
);
    logic mapped;
    assign mapped = (PADDR >> 2) inside {[10'h3f6:10'h3fb]};
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    AST_READY_TIME: assert property (PSEL && $rose(PENABLE) |=> PREADY)
        else $error("ready not one cycle into access");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_READY_IDLE: assert property (!(PSEL && PENABLE) |=> !PREADY)
        else $error("ready outside an access");
    AST_ERR_MAP: assert property (PREADY |-> PSLVERR == !mapped)
        else $error("error flag does not match the map");
    AST_RD_UPPER: assert property (PREADY && !PWRITE |-> !(|PRDATA[31:10]))
        else $error("upper read bits not zero");
    AST_RD_CMD: assert property (
        PREADY && !PWRITE && (PADDR[3] || !mapped) |-> PRDATA == '0)
        else $error("command word reads nonzero");
    // only a bus write may drop the request, events only raise it
    AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(PREADY && PWRITE, 2))
        else $error("request fell without a write");
    AST_RST_QUIET: assert property (!$past(RST_N) |-> !IRQ && !PREADY)
        else $error("outputs active after reset");
endmodule

bind nvm_event_interrupt_regs nvm_irq_chk #(.AW(AW)) i_nvm_irq_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ));

// File: dv/tb_top.sv
// Purpose: self-checking bench of the event interrupt register set
// Assumes: full byte strobes on every write but one lane test
// Notes: the bench is both bus master and memory controller
`timescale 1ns/10ps

module tb_top;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, r, prd;
    logic [9:0] ev = '0;
    logic [3:0] pst = 4'hf;
    logic rdy, err, irq;
    int n_mismatch = 0, n_tests = 0;
    always #5 clk = ~clk;
    nvm_event_interrupt_regs i_nvm_event_interrupt_regs (
        .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(pst),
        .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
        .EEPROM_WRITE_DONE(ev[0]), .BANK0_WRITE_DONE(ev[1]),
        .BANK1_WRITE_DONE(ev[2]), .EEPROM_HV_FAULT(ev[3]),
        .BANK0_HV_FAULT(ev[4]), .BANK1_HV_FAULT(ev[5]),
        .BANK0_ECC_INVALID(ev[6]), .BANK0_ECC_UNCORR(ev[7]),
        .BANK1_ECC_INVALID(ev[8]), .BANK1_ECC_UNCORR(ev[9]),
        .IRQ(irq));
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, s);
        n_tests++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, x, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        // read right after the edge still sees the pre-edge answer
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        r = prd;
        e = err;
        psel <= 0;
        pen <= 0;
        if (n >= 20)
            chk("pready", 1, 0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1, a, d);
        chk("slverr", 0, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input string nm);
        bus(0, a, 0);
        chk(nm, x, r);
    endtask
    task automatic t_reset;
        rd(12'hfe0, 0, "pend");
        rd(12'hfe4, 0, "ena");
        chk("irq", 0, irq);
        $display("t_reset done");
    endtask
    task automatic t_enable;
        wr(12'hfdc, 32'hffff_ffff);
        rd(12'hfe4, 32'h3ff, "ena");
        wr(12'hfd8, 32'h155);
        rd(12'hfe4, 32'h2aa, "ena");
        wr(12'hfe4, 32'h3ff);
        rd(12'hfe4, 32'h2aa, "ena");
        rd(12'hfdc, 0, "cmd");
        $display("t_enable done");
    endtask
    task automatic t_events;
        for (int i = 0; i < 10; i++) begin
            wr(12'hfe8, 32'h3ff);
            ev <= 10'h1 << i;
            @(posedge clk);
            ev <= '0;
            rd(12'hfe0, 32'h1 << i, "pend");
            chk("irq", (32'h2aa >> i) & 1, irq);
        end
        $display("t_events done");
    endtask
    task automatic t_soft;
        wr(12'hfe8, 32'h3ff);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        wr(12'hfec, 32'hffff_fe01);
        rd(12'hfe0, 32'h201, "pend");
        chk("irq", 1, irq);
        wr(12'hfe8, 32'h200);
        rd(12'hfe0, 32'h1, "pend");
        chk("irq", 0, irq);
        wr(12'hfe0, 32'h3ff);
        rd(12'hfe0, 32'h1, "pend");
        bus(0, 12'h000, 0);
        chk("slverr", 1, e);
        chk("rdata", 0, r);
        // only the second byte lane may act: bits 9:8 are set
        pst <= 4'h2;
        wr(12'hfec, 32'h0000_03fe);
        pst <= 4'hf;
        rd(12'hfe0, 32'h301, "pend");
        $display("t_soft done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        t_reset;
        t_enable;
        t_events;
        t_soft;
        close_out;
    end
    // whole run is well under a thousand cycles
    initial begin
        #200us;
        n_mismatch++;
        close_out;
    end
endmodule
